// ===== cdrs_pkg.sv
// package of the clock divider and reset synchroniser
// assumes one system clock samples every pin of the block
package cdrs_pkg;

    // position of each pin in the synchroniser bank
    localparam int unsigned SYN_OSC = 0;
    localparam int unsigned SYN_EXT = 1;
    localparam int unsigned SYN_SEL = 2;
    localparam int unsigned SYN_REQ = 3;
    localparam int unsigned SYN_W   = 4;

    // first fetch delay, in processor clock half periods (6 1/2 clocks)
    localparam int unsigned FETCH_DELAY_HALF = 13;
    // one processor clock half period is one oscillator cycle
    localparam int unsigned OSC_PER_HALF     = 1;
    localparam int unsigned FETCH_OSC_CYCLES = FETCH_DELAY_HALF * OSC_PER_HALF;

    // fixed start address of the first instruction fetch
    localparam logic [19:0] FETCH_ADDR = 20'hffff0;

    // reset values
    localparam logic RST_CPU_CLK = 1'b1;
    localparam logic RST_REQ     = 1'b1;
    localparam logic RST_SYSRST  = 1'b1;

    // reset sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_CLEAR = 4'h2,
        ST_RESET = 4'h4,
        ST_START = 4'h8
    } cdrs_state_e;

endpackage

// ===== cdrs_sync.sv
// two flip-flop synchroniser bank with edge detection
// assumes the inputs are asynchronous pins and clk_i is the system clock
`timescale 1ns/1ps
module cdrs_sync #(
    parameter int unsigned W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] last_q;

    // a bank needs at least one pin
    if (W < 1) begin : g_bad_w
        $error("cdrs_sync: W must be at least 1");
    end

    // one chain per pin; meta_q feeds sync_q only
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (!nrst_i) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
                last_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_i[i];
                sync_q[i] <= meta_q[i];
                last_q[i] <= sync_q[i];
            end
        end
        assign level_o[i] = sync_q[i];
        assign rise_o[i]  = sync_q[i] & ~last_q[i];
        assign fall_o[i]  = ~sync_q[i] & last_q[i];
    end
endmodule

// ===== cdrs_top.sv
// clock divider and reset synchroniser: divides the oscillator by two,
// sequences the clear pulse, system reset and first fetch strobe
// assumes clk_i is far faster than the oscillator so every edge is seen
//
// Notes on behaviour
// - the processor clock is the oscillator divided by two, so its duty is 50 percent whatever the input duty.
// - the clock output toggles only on oscillator falling edges, apart from being set high by the clear pulse, and keeps running during reset.
// - the active-low reset request is sampled on rising oscillator edges.
// - a newly active request starts a one oscillator cycle clear pulse, rising edge to rising edge, that clears the divider.
// - the clock output is high during the clear pulse, goes low on the next falling edge and toggles after that.
// - the request is synchronised to the processor clock and the system reset output updates on its falling edges.
// - the system reset output lasts a whole number of processor clocks that tracks the request length.
// - the system reset output falls on the second processor clock falling edge after the request is sampled inactive.
// - the first fetch from the fixed start address begins 6 1/2 processor clocks after the request goes inactive.
`timescale 1ns/1ps
module cdrs_top
    import cdrs_pkg::*;
#(
    parameter int unsigned FETCH_CYCLES = cdrs_pkg::FETCH_OSC_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic        osc_in_i,
    input  wire logic        ext_freq_in_i,
    input  wire logic        ext_freq_sel_i,
    input  wire logic        power_on_clear_n_i,
    output logic             osc_out_o,
    output logic             cpu_clock_out_o,
    output logic             sys_reset_o,
    output logic             clear_pulse_o,
    output logic             fetch_start_o,
    output logic [19:0]      fetch_addr_o
);
    import cdrs_pkg::*;

    // range that the four bit fetch counter can serve
    if (FETCH_CYCLES < 1 || FETCH_CYCLES > 15) begin : g_bad_fetch
        $error("cdrs_top: FETCH_CYCLES must be 1..15");
    end

    localparam logic [3:0] FETCH_LAST = 4'(FETCH_CYCLES - 1);

    logic [SYN_W-1:0] syn_lvl;
    logic [SYN_W-1:0] syn_rise;
    logic [SYN_W-1:0] syn_fall;
    logic             osc_lvl;
    logic             osc_rise;
    logic             osc_fall;
    logic             req_act;
    logic             cpu_fall_evt;
    logic             req_samp_q;
    logic             stage1_q;
    logic             sys_reset_q;
    logic             cpu_clk_q;
    logic             osc_out_q;
    logic             fetch_q;
    logic [19:0]      fetch_addr_q;
    logic [3:0]       cnt_q;
    cdrs_state_e      state_q;

    // every pin passes two flip-flops first
    cdrs_sync #(
        .W       (SYN_W)
    ) u_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i ({power_on_clear_n_i, ext_freq_sel_i, ext_freq_in_i, osc_in_i}),
        .level_o (syn_lvl),
        .rise_o  (syn_rise),
        .fall_o  (syn_fall)
    );

    // source select; a change of source may look like one extra edge
    assign osc_lvl  = syn_lvl[SYN_SEL] ? syn_lvl[SYN_EXT]  : syn_lvl[SYN_OSC];
    assign osc_rise = syn_lvl[SYN_SEL] ? syn_rise[SYN_EXT] : syn_rise[SYN_OSC];
    assign osc_fall = syn_lvl[SYN_SEL] ? syn_fall[SYN_EXT] : syn_fall[SYN_OSC];
    assign req_act  = ~syn_lvl[SYN_REQ];

    // processor clock falling edge happens on an oscillator falling edge
    assign cpu_fall_evt = osc_fall & cpu_clk_q & (state_q != ST_CLEAR);

    // request taken only on rising oscillator edges
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            req_samp_q <= RST_REQ;
        end else if (osc_rise) begin
            req_samp_q <= req_act;
        end
    end

    // reset sequencer: clear pulse, reset hold, fetch delay
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            state_q <= ST_RESET;
            cnt_q   <= 4'h0;
            fetch_q <= 1'b0;
        end else begin
            fetch_q <= 1'b0;
            if (osc_rise) begin
                case (state_q)
                    ST_RUN: begin
                        if (req_act) state_q <= ST_CLEAR;
                    end
                    ST_CLEAR: begin
                        state_q <= ST_RESET;
                    end
                    ST_RESET: begin
                        if (!req_act) begin
                            state_q <= ST_START;
                            cnt_q   <= 4'h0;
                        end
                    end
                    ST_START: begin
                        if (req_act) begin
                            state_q <= ST_CLEAR;
                        end else if (cnt_q == FETCH_LAST) begin
                            state_q <= ST_RUN;
                            fetch_q <= 1'b1;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                    default: begin
                        state_q <= ST_RESET;
                    end
                endcase
            end
        end
    end

    // divide by two; forced high during the clear pulse
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cpu_clk_q <= RST_CPU_CLK;
        end else if (state_q == ST_CLEAR) begin
            cpu_clk_q <= 1'b1;
        end else if (osc_fall) begin
            cpu_clk_q <= ~cpu_clk_q;
        end
    end

    // two stage resync on processor clock falling edges
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            stage1_q    <= RST_SYSRST;
            sys_reset_q <= RST_SYSRST;
        end else if (cpu_fall_evt) begin
            stage1_q    <= req_samp_q;
            sys_reset_q <= stage1_q;
        end
    end

    // processor clock falls since the sampled request went inactive, for the release check
    logic [1:0] rel_cnt_q;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rel_cnt_q <= 2'h0;
        end else if (req_samp_q) begin
            rel_cnt_q <= 2'h0;
        end else if (cpu_fall_evt && rel_cnt_q != 2'h3) begin
            rel_cnt_q <= rel_cnt_q + 2'h1;
        end
    end

    // crystal drive and fixed fetch address
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            osc_out_q    <= 1'b1;
            fetch_addr_q <= FETCH_ADDR;
        end else begin
            osc_out_q    <= ~osc_lvl;
            fetch_addr_q <= FETCH_ADDR;
        end
    end

    // clear pulse is shown as registered
    logic clear_q;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            clear_q <= 1'b0;
        end else begin
            clear_q <= (state_q == ST_CLEAR);
        end
    end

    assign osc_out_o       = osc_out_q;
    assign cpu_clock_out_o = cpu_clk_q;
    assign sys_reset_o     = sys_reset_q;
    assign clear_pulse_o   = clear_q;
    assign fetch_start_o   = fetch_q;
    assign fetch_addr_o    = fetch_addr_q;

    // checks on clock, clear and reset sequencing
    clk_fall_only_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $changed(cpu_clk_q) |-> $past(osc_fall) || $past(state_q == ST_CLEAR))
        else $error("clock output changed without a falling oscillator edge");

    clk_divides_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (osc_fall && state_q != ST_CLEAR) |=> $changed(cpu_clk_q))
        else $error("clock output missed a toggle");

    clear_high_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (state_q == ST_CLEAR) |=> cpu_clk_q)
        else $error("clock output low during clear");

    clear_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (osc_rise && state_q == ST_RUN && req_act) |=> (state_q == ST_CLEAR))
        else $error("clear pulse did not start");

    clear_one_osc_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (osc_rise && state_q == ST_CLEAR) |=> (state_q == ST_RESET))
        else $error("clear pulse longer than one oscillator cycle");

    sample_rise_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $changed(req_samp_q) |-> $past(osc_rise))
        else $error("request sampled off a rising edge");

    reset_on_fall_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $changed(sys_reset_q) |-> $past(cpu_fall_evt))
        else $error("system reset changed off a clock falling edge");

    reset_release_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(sys_reset_q) |-> rel_cnt_q == 2'h2)
        else $error("system reset released early");

    reset_tracks_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cpu_fall_evt && stage1_q) |=> sys_reset_q)
        else $error("system reset dropped while request held");

    fetch_start_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fetch_q |-> $past(state_q == ST_START && cnt_q == FETCH_LAST && osc_rise))
        else $error("fetch strobe at wrong time");

    clear_seen_c:   cover property (@(posedge clk_i) disable iff (!nrst_i) state_q == ST_CLEAR);
    reset_drop_c:   cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(sys_reset_q));
    fetch_seen_c:   cover property (@(posedge clk_i) disable iff (!nrst_i) fetch_q);
    reclear_c:      cover property (@(posedge clk_i) disable iff (!nrst_i)
        state_q == ST_START ##1 state_q == ST_CLEAR);
endmodule

// ===== cdrs_partner.sv
// oscillator, external frequency source and power-on reset network model
// assumes clk_i is the 10 MHz system clock; pins change just after its rising edge
`timescale 1ns/1ps
module cdrs_partner #(
    parameter int unsigned HALF = 8
) (
    input  wire logic clk_i,
    input  wire logic sel_i,
    input  wire logic rst_req_i,
    output logic      osc_in_o,
    output logic      ext_in_o,
    output logic      req_n_o
);
    int unsigned ph_q;
    int unsigned low_q;
    initial begin
        ph_q = 0;
        low_q = 0;
        osc_in_o = 1'b0;
        ext_in_o = 1'b0;
        req_n_o = 1'b0;
    end
    // oscillator at 50 percent duty, external source at 25 percent, same period
    always @(posedge clk_i) begin
        ph_q <= (ph_q + 1) % (2 * HALF);
        osc_in_o <= (ph_q < HALF);
        ext_in_o <= (ph_q >= 3 && ph_q < 3 + HALF / 2);
    end
    // request low from power-up, held four processor clocks, freed after a source fall
    always @(posedge clk_i) begin
        low_q <= req_n_o ? 0 : low_q + 1;
        if (rst_req_i)
            req_n_o <= 1'b0;
        else if (low_q >= 16 * HALF && ph_q == (sel_i ? 4 + HALF / 2 : HALF + 1))
            req_n_o <= 1'b1;
    end
endmodule

// ===== test_clock_divider_reset_sync.sv
// self-checking bench of the clock divider and reset synchroniser
// assumes cdrs_pkg, cdrs_top and cdrs_partner are compiled first
`timescale 1ns/1ps
`define CHK(what, exp, got) begin compares++; if ((exp) !== (got)) begin bad_count++; \
    $display("FAIL %s expected %0d seen %0d", what, exp, got); end end
module test_clock_divider_reset_sync;
    import cdrs_pkg::*;
    localparam int HALF = 8;
    localparam int FC = 3;
    logic clk_i = 0, nrst_i = 0, sel = 0, rst_req = 0, osc_in, ext_in, req_n;
    logic osc_out, cpu_clock_out_o, sys_reset_o, clear_pulse_o, fetch_start_o;
    logic [19:0] fetch_addr_o;
    logic src, p_src = 0, p_sel = 0, p_cpu = 0, p_clr = 0, p_rst = 0, p_req = 0;
    int bad_count = 0, compares = 0, seed, n, e, fetch_n = 0, exp_q[$];
    int t = 0, s_rise = 0, s_fall = 0, cr_t = 0, cf_t = 0, clr_t = 0, rst_t = 0, req_t = 0;
    int req_len = 0, rises = 0, falls = 0;
    int per_skip = 1, sel_t = 0;
    logic [2:0] src_h = 3'h0;
    cdrs_partner #(.HALF(HALF)) i_cdrs_partner (.clk_i(clk_i), .sel_i(sel), .rst_req_i(rst_req),
        .osc_in_o(osc_in), .ext_in_o(ext_in), .req_n_o(req_n));
    cdrs_top #(.FETCH_CYCLES(FC)) i_cdrs_top (.clk_i(clk_i), .nrst_i(nrst_i), .osc_in_i(osc_in),
        .ext_freq_in_i(ext_in), .ext_freq_sel_i(sel), .power_on_clear_n_i(req_n), .osc_out_o(osc_out),
        .cpu_clock_out_o(cpu_clock_out_o), .sys_reset_o(sys_reset_o), .clear_pulse_o(clear_pulse_o),
        .fetch_start_o(fetch_start_o), .fetch_addr_o(fetch_addr_o));
    // system clock, 100 ns period
    initial forever #50 clk_i = ~clk_i;
    task automatic wrap_up();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // output watcher: measures edges in system clocks and takes expectations off the queue
    always @(posedge clk_i) if (nrst_i) begin
        t++;
        s_rise++;
        s_fall++;
        src = sel ? ext_in : osc_in;
        if (src && !p_src) begin
            s_rise = 0;
            rises++;
        end
        if (!src && p_src) s_fall = 0;
        if (sel !== p_sel) begin
            per_skip = 2;
            sel_t = t;
        end
        if (cpu_clock_out_o === 1'b1 && !p_cpu) cr_t = t;
        if (cpu_clock_out_o === 1'b0 && p_cpu) begin
            `CHK("cpu fall lag", 1, s_fall <= 5)
            if (per_skip == 0) `CHK("cpu period", 4 * HALF, t - cf_t)
            if (per_skip == 0) `CHK("cpu high", 2 * HALF, t - cr_t)
            if (per_skip > 0) per_skip--;
            cf_t = t;
            if (rises > 0) falls++;
        end
        if (clear_pulse_o === 1'b1) begin
            if (per_skip == 0) per_skip = 1;
            `CHK("cpu in clear", 1'b1, cpu_clock_out_o)
        end
        if (clear_pulse_o === 1'b1 && !p_clr) begin
            clr_t = t;
            `CHK("clear after rise", 1, s_rise <= 5)
        end
        if (clear_pulse_o === 1'b0 && p_clr) `CHK("clear length", 2 * HALF, t - clr_t)
        if (!req_n && p_req) req_t = t;
        if (req_n && !p_req) begin
            rises = 0;
            falls = 0;
            req_len = t - req_t;
        end
        if (sys_reset_o === 1'b1 && !p_rst) rst_t = t;
        if (sys_reset_o === 1'b0 && p_rst) begin
            `CHK("cpu falls to release", 2, falls)
            if (req_t > 0) `CHK("reset whole clocks", 0, (t - rst_t) % (4 * HALF))
            if (req_t > 0) `CHK("reset tracks request", 1, (t - rst_t - req_len) inside {[-64:32]})
        end
        if (fetch_start_o === 1'b1) begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : -1;
            `CHK("source rises to fetch", e, rises)
            `CHK("fetch address", FETCH_ADDR, fetch_addr_o)
            fetch_n++;
        end
        // crystal drive is the inverted source, three system clocks behind what the watcher saw
        if (t > 4 && t - sel_t > 6) `CHK("crystal drive", ~src_h[2], osc_out)
        src_h = {src_h[1:0], src};
        {p_src, p_sel, p_cpu, p_clr, p_rst, p_req} = {src, sel, cpu_clock_out_o, clear_pulse_o, sys_reset_o, req_n};
    end
    // main sequence: power-up release, then two requests of random length, the last on the external source
    initial begin
        seed = 48;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            exp_q.push_back(FC + 1);
            n = fetch_n;
            if (k > 0) rst_req <= 1'b1;
            repeat (40) @(posedge clk_i);
            if (k == 2) sel <= 1'b1;
            repeat ($unsigned($random(seed)) % 200) @(posedge clk_i);
            rst_req <= 1'b0;
            for (int w = 0; w < 3000 && fetch_n == n; w++) @(posedge clk_i);
            `CHK("fetch seen", n + 1, fetch_n)
            repeat (100) @(posedge clk_i);
        end
        wrap_up();
    end
    // watchdog well past the longest expected run
    initial begin
        #1500000;
        bad_count++;
        wrap_up();
    end
endmodule
